// ---- rtl/adc_out_pkg.sv ----
// Purpose: shared constants, types and decoders for the sample output block
// Assumes: 250 MHz ref_clk, APB register access, 14-bit sample words
// Notes: strap levels arrive already resolved into four-level codes
// Summary of operation
// - each sample reaches the latched output seven clocks after capture
// - output word changes just after the rising edge; receiver samples later
// - samples are taken on the rising clock edge only
// - restorer active gives a regenerated half-period internal clock
// - restorer active tolerates input clock duty from 30% to 70%
// - after a rate change the loop needs about 100 clocks to relock
// - standby request shuts reference, reference buffer and bias down
// - in standby every parallel output driver is high impedance
// - dropping the standby request returns to normal conversion
// - wake-up grows with standby time, up to 7 ms after 1 s
// - each sample is a 14-bit parallel word
// - output encoding is offset binary or two's complement
// - four-level mode strap selects format and restorer state
// - four-level reference select picks external, 0.5 V, programmable, 1.0 V
package adc_out_pkg;

   localparam int SAMPLE_W = 14;
   localparam int PIPE_LATENCY = 7;
   localparam int RELOCK_CYCLES = 100;
   localparam int DISCARD_WORDS = 7;
   localparam int FIFO_DEPTH = 16;

   // time figures and derived cycle counts
   localparam int CLK_MHZ = 250;
   localparam int STANDBY_FULL_S = 1;
   localparam int WAKE_FULL_MS = 7;
   localparam int STANDBY_FULL_CYC = STANDBY_FULL_S * CLK_MHZ * 1000000;
   localparam int WAKE_FULL_CYC = WAKE_FULL_MS * CLK_MHZ * 1000;

   // register map
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] FIFO_OFS = 12'h008;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int CTRL_STBY_BIT = 0;
   localparam int CTRL_CAP_BIT = 1;
   localparam int FIFO_VALID_BIT = 31;

   typedef enum logic [1:0] {LVL_GROUND, LVL_THIRD, LVL_TWO_THIRDS, LVL_SUPPLY} strap_level_type;
   typedef enum logic [1:0] {REF_FIXED_1V0, REF_PROGRAM, REF_FIXED_0V5, REF_EXTERNAL} ref_mode_type;

   typedef struct packed {
      logic twos;
      logic restorer;
   } mode_cfg_type;

   // mode strap to format and restorer state
   function automatic mode_cfg_type decode_mode(strap_level_type lvl);
      mode_cfg_type m;
      m.twos = (lvl == LVL_SUPPLY) || (lvl == LVL_TWO_THIRDS);
      m.restorer = (lvl == LVL_TWO_THIRDS) || (lvl == LVL_THIRD);
      return m;
   endfunction

   // reference select level to reference mode
   function automatic ref_mode_type decode_ref(strap_level_type lvl);
      ref_mode_type r;
      unique case (lvl)
         LVL_SUPPLY: r = REF_EXTERNAL;
         LVL_TWO_THIRDS: r = REF_FIXED_0V5;
         LVL_THIRD: r = REF_PROGRAM;
         LVL_GROUND: r = REF_FIXED_1V0;
      endcase
      return r;
   endfunction

   // offset binary to two's complement by msb flip
   function automatic logic [SAMPLE_W-1:0] format_word(logic [SAMPLE_W-1:0] w, logic twos);
      return {w[SAMPLE_W-1] ^ twos, w[SAMPLE_W-2:0]};
   endfunction

endpackage

// ---- rtl/adc_sample_output.sv ----
// Purpose: sample output pipeline, restorer lock, standby and wake control
// Assumes: raw words arrive offset binary, one per ref_clk
// Notes: capture fifo lets software read output words over APB
//
// Implementation choices: the address map and the APB interface to the registers.

// word buffer with valid and ready on both sides
module sample_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // honest flags from occupancy
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   // storage
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sample_fifo

module adc_sample_output #(
   parameter int STANDBY_CYC = adc_out_pkg::STANDBY_FULL_CYC,
   parameter int WAKE_CYC = adc_out_pkg::WAKE_FULL_CYC,
   parameter int FIFO_DEPTH = adc_out_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [adc_out_pkg::SAMPLE_W-1:0] sample_in,
   input wire adc_out_pkg::strap_level_type mode_level,
   input wire adc_out_pkg::strap_level_type sense_level,
   input wire logic standby_request,
   input wire logic rate_change,
   output logic [adc_out_pkg::SAMPLE_W-1:0] data_out,
   output logic data_oe,
   output logic restorer_enable,
   output logic dll_locked,
   output adc_out_pkg::ref_mode_type ref_mode,
   output logic ref_enable,
   output logic ref_buffer_enable,
   output logic bias_enable,
   output logic samples_valid,
   output logic capture_ready,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int W = adc_out_pkg::SAMPLE_W;
   localparam int LAT = adc_out_pkg::PIPE_LATENCY;
   localparam int SBW = $clog2(STANDBY_CYC + 1);
   localparam int WKW = $clog2(WAKE_CYC + 1);
   localparam int RATIO = STANDBY_CYC / WAKE_CYC;
   localparam int RLW = $clog2(adc_out_pkg::RELOCK_CYCLES + 1);
   localparam int DSW = $clog2(adc_out_pkg::DISCARD_WORDS + 1);

   adc_out_pkg::mode_cfg_type mode_q;
   adc_out_pkg::ref_mode_type ref_q;
   logic [W-1:0] pipe_q [0:LAT-1];
   logic [W-1:0] data_q;
   logic standby_q;
   logic [RLW-1:0] relock_q;
   logic [SBW-1:0] stby_cnt_q;
   logic [WKW-1:0] wake_q;
   logic [DSW-1:0] disc_q;
   logic [1:0] ctrl_q;
   logic ack_q;
   logic [31:0] prdata_q;
   logic fifo_ready;
   logic fifo_valid;
   logic [W-1:0] fifo_word;

   // straps caught while reset is held
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mode_q <= adc_out_pkg::decode_mode(mode_level);
         ref_q <= adc_out_pkg::decode_ref(sense_level);
      end
   end

   assign restorer_enable = mode_q.restorer;
   assign ref_mode = ref_q;

   // sample capture and delay line
   always_ff @(posedge ref_clk)
   begin
      pipe_q[0] <= rst ? '0 : sample_in;
   end

   generate
      for (genvar i = 1; i < LAT; i++)
      begin : g_pipe
         always_ff @(posedge ref_clk)
         begin
            pipe_q[i] <= rst ? '0 : pipe_q[i-1];
         end
      end
   endgenerate

   // latched, formatted output word
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         data_q <= '0;
      end
      else
      begin
         data_q <= adc_out_pkg::format_word(pipe_q[LAT-1], mode_q.twos);
      end
   end

   // output driven straight from the latch
   assign data_out = data_q;

   // standby request from pin or control bit
   wire stby_req = standby_request || ctrl_q[adc_out_pkg::CTRL_STBY_BIT];
   wire wake_edge = standby_q && !stby_req;

   always_ff @(posedge ref_clk)
   begin
      standby_q <= rst ? 1'b0 : stby_req;
   end

   assign ref_enable = !standby_q;
   assign ref_buffer_enable = !standby_q;
   assign bias_enable = !standby_q;
   assign data_oe = !standby_q;

   // time spent in standby, saturating
   always_ff @(posedge ref_clk)
   begin
      if (rst || !standby_q)
      begin
         stby_cnt_q <= '0;
      end
      else if (stby_cnt_q != SBW'(STANDBY_CYC))
      begin
         stby_cnt_q <= stby_cnt_q + 1'b1;
      end
   end

   // wake time scales with standby time
   wire [WKW-1:0] wake_load = WKW'(stby_cnt_q / SBW'(RATIO));

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wake_q <= '0;
      end
      else if (wake_edge)
      begin
         wake_q <= wake_load;
      end
      else if (wake_q != '0)
      begin
         wake_q <= wake_q - 1'b1;
      end
   end

   // restorer loop lock model
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         relock_q <= RLW'(adc_out_pkg::RELOCK_CYCLES);
      end
      else if (rate_change)
      begin
         relock_q <= RLW'(adc_out_pkg::RELOCK_CYCLES);
      end
      else if (relock_q != '0)
      begin
         relock_q <= relock_q - 1'b1;
      end
   end

   // restorer hides input duty once locked
   assign dll_locked = mode_q.restorer && (relock_q == '0);
   wire clk_ok = !mode_q.restorer || dll_locked;
   wire settled = !standby_q && (wake_q == '0) && clk_ok;

   // stale pipeline words after wake or relock
   always_ff @(posedge ref_clk)
   begin
      if (rst || !settled)
      begin
         disc_q <= DSW'(adc_out_pkg::DISCARD_WORDS);
      end
      else if (disc_q != '0)
      begin
         disc_q <= disc_q - 1'b1;
      end
   end

   // valid only after stale words pass
   assign samples_valid = settled && (disc_q == '0);

   // apb decode, one wait state per access
   wire acc = psel && penable;
   wire hit_ctrl = (paddr == adc_out_pkg::CTRL_OFS);
   wire hit_stat = (paddr == adc_out_pkg::STATUS_OFS);
   wire hit_fifo = (paddr == adc_out_pkg::FIFO_OFS);
   wire hit = hit_ctrl || hit_stat || hit_fifo;
   wire done = acc && ack_q;
   wire [31:0] stat_word = {22'h0, !fifo_ready, !fifo_valid, ref_q, mode_q,
      samples_valid, (wake_q != '0), dll_locked, standby_q};
   wire [31:0] fifo_rd = {fifo_valid, 17'h0, fifo_word};
   wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
      hit_stat ? stat_word : hit_fifo ? fifo_rd : 32'h00000000;
   wire pop = done && !pwrite && hit_fifo && prdata_q[adc_out_pkg::FIFO_VALID_BIT];

   assign pready = done;
   assign pslverr = done && !hit;
   assign prdata = prdata_q;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         prdata_q <= '0;
         ctrl_q <= adc_out_pkg::CTRL_RST;
      end
      else
      begin
         ack_q <= acc && !ack_q;
         if (acc && !ack_q) prdata_q <= pwrite ? 32'h00000000 : rd_mux;
         if (done && pwrite && hit_ctrl) ctrl_q <= pwdata[1:0];
      end
   end

   // capture path drops words while buffer is full
   wire cap_valid = ctrl_q[adc_out_pkg::CTRL_CAP_BIT] && samples_valid;
   assign capture_ready = fifo_ready;

   sample_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(cap_valid),
      .in_ready(fifo_ready),
      .in_data(data_q),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_word)
   );

   // assertion helpers
   logic [3:0] run_q;
   always_ff @(posedge ref_clk)
   begin
      if (rst) run_q <= '0;
      else if (run_q != 4'h9) run_q <= run_q + 1'b1;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_latency;
      run_q == 4'h9 |-> data_out == adc_out_pkg::format_word($past(sample_in, 8), mode_q.twos);
   endproperty
   a_latency: assert property (p_latency) else $error("output latency wrong");

   property p_tristate;
      standby_q |-> !data_oe && !ref_enable && !bias_enable;
   endproperty
   a_tristate: assert property (p_tristate) else $error("driver on in standby");

   property p_enter;
      stby_req |=> standby_q && !ref_buffer_enable;
   endproperty
   a_enter: assert property (p_enter) else $error("standby not entered");

   property p_leave;
      $fell(stby_req) |=> data_oe;
   endproperty
   a_leave: assert property (p_leave) else $error("standby not left");

   sequence s_unlocked;
      (!dll_locked)[*8];
   endsequence
   sequence s_relocked;
      ##[1:100] (dll_locked || rate_change || rst);
   endsequence
   property p_relock;
      rate_change && mode_q.restorer |=> s_unlocked ##0 s_relocked;
   endproperty
   a_relock: assert property (p_relock) else $error("relock timing wrong");

   property p_valid;
      samples_valid |-> !standby_q && wake_q == '0 && clk_ok && $past(settled, 7);
   endproperty
   a_valid: assert property (p_valid) else $error("valid too early");

   property p_discard;
      $rose(settled) |-> !samples_valid [*7] ##1 samples_valid || !settled;
   endproperty
   a_discard: assert property (p_discard) else $error("discard count wrong");

   property p_mode;
      $fell(rst) |-> mode_q == adc_out_pkg::decode_mode($past(mode_level))
         && ref_mode == adc_out_pkg::decode_ref($past(sense_level));
   endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");

   property p_apb;
      acc && !ack_q |=> pready || !acc;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
endmodule // adc_sample_output

// ---- dv/sample_receiver.sv ----
// Purpose: receiving logic that captures parallel sample words
// Assumes: one word per ref_clk, trust qualifies the pins
// Notes: stale pipeline words are dropped before keeping any

module sample_receiver (
   input wire logic ref_clk,
   input wire logic [13:0] pins,
   input wire logic trust,
   output int kept,
   output logic [13:0] last_word
);
   timeunit 1ns;
   timeprecision 1ps;

   int skip;

   initial
   begin
      kept = 0;
      skip = 0;
      last_word = 14'h0000;
   end

   // capture one edge after launch, so the output delay has passed
   // wait, then keep
   always @(posedge ref_clk)
   begin
      if (!trust)
         skip <= 0;
      else if (skip < 7)
         skip <= skip + 1;
      else
      begin
         kept <= kept + 1;
         last_word <= pins;
      end
   end
endmodule // sample_receiver

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the sample output block
// Assumes: apb master tasks, receiver model on the pins
// Notes: short standby and wake parameters keep the run brief

`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("Error %0t %s", $time, m); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 0, rst = 1, standby_request = 0, rate_change = 0;
   logic [13:0] sample_in = 14'h0000;
   adc_out_pkg::strap_level_type mode_level = adc_out_pkg::LVL_GROUND;
   adc_out_pkg::strap_level_type sense_level = adc_out_pkg::LVL_GROUND;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [13:0] data_out, last_word, prev_word;
   logic data_oe, restorer_enable, dll_locked, ref_enable, ref_buffer_enable, bias_enable;
   logic samples_valid, capture_ready, pready, pslverr, err;
   adc_out_pkg::ref_mode_type ref_mode;
   int n_errors = 0, n_compared = 0, cyc = 0, tick = 0, kept, i, k;
   wire logic [13:0] pins;
   wire logic trust;

   // pins float while drivers are off; receiver trusts only settled words
   assign pins = data_oe ? data_out : 14'hzzzz;
   assign trust = samples_valid & data_oe & (dll_locked | ~restorer_enable);

   adc_sample_output #(.STANDBY_CYC(1000), .WAKE_CYC(7)) adc_sample_output_i (
      .ref_clk(ref_clk), .rst(rst), .sample_in(sample_in), .mode_level(mode_level),
      .sense_level(sense_level), .standby_request(standby_request),
      .rate_change(rate_change), .data_out(data_out), .data_oe(data_oe),
      .restorer_enable(restorer_enable), .dll_locked(dll_locked), .ref_mode(ref_mode),
      .ref_enable(ref_enable), .ref_buffer_enable(ref_buffer_enable),
      .bias_enable(bias_enable), .samples_valid(samples_valid),
      .capture_ready(capture_ready), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   sample_receiver sample_receiver_i (
      .ref_clk(ref_clk), .pins(pins), .trust(trust), .kept(kept), .last_word(last_word));

   // free-running ungated source, far above the minimum rate
   // clean fast clock
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   // sample stream and hang guard
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      sample_in <= 14'((cyc + 1) * 37);
      tick = tick + 1;
      if (tick == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   function automatic logic [13:0] fmt(input logic [13:0] w, input logic t);
      return {w[13] ^ t, w[12:0]};
   endfunction

   task automatic print_verdict;
      if (n_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wait_valid;
      i = 0;
      while (samples_valid !== 1'b1 && i < 100)
      begin
         @(negedge ref_clk);
         i++;
      end
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 0;
      apb(0, adc_out_pkg::CTRL_OFS, 0);
      `CHK(rd, 32'h0000_0000, "ctrl reset")
      for (k = 0; k < 4; k++)
      begin
         @(posedge ref_clk);
         mode_level <= adc_out_pkg::strap_level_type'(k);
         sense_level <= adc_out_pkg::strap_level_type'(3 - k);
         rst <= 1;
         repeat (3) @(posedge ref_clk);
         rst <= 0;
         repeat (12) @(negedge ref_clk);
         `CHK(restorer_enable, logic'(k == 1 || k == 2), "restorer")
         `CHK(ref_mode, adc_out_pkg::ref_mode_type'(3 - k), "ref mode")
         repeat (8)
         begin
            @(negedge ref_clk);
            `CHK(data_out, fmt(14'((cyc - 8) * 37), k >= 2), "latency")
         end
         apb(0, adc_out_pkg::STATUS_OFS, 0);
         `CHK(rd[5], logic'(k >= 2), "format status")
      end
      @(posedge ref_clk);
      mode_level <= adc_out_pkg::LVL_TWO_THIRDS;
      rst <= 1;
      repeat (3) @(posedge ref_clk);
      rst <= 0;
      repeat (150) @(negedge ref_clk);
      `CHK(dll_locked, 1'b1, "lock")
      @(posedge ref_clk);
      rate_change <= 1;
      @(posedge ref_clk);
      rate_change <= 0;
      @(negedge ref_clk);
      i = 0;
      while (dll_locked !== 1'b1 && i < 300)
      begin
         @(negedge ref_clk);
         i++;
      end
      `CHK(i >= 98 && i <= 102, 1'b1, "relock time")
      @(posedge ref_clk);
      standby_request <= 1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0, "oe in standby")
      `CHK({ref_enable, ref_buffer_enable, bias_enable}, 3'b000, "power down")
      repeat (1000) @(posedge ref_clk);
      standby_request <= 0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b1, "oe after wake")
      `CHK(samples_valid, 1'b0, "early valid")
      wait_valid();
      `CHK(i >= 10 && i <= 18, 1'b1, "wake time")
      k = kept;
      repeat (20) @(negedge ref_clk);
      `CHK(kept > 0 && !$isunknown(last_word), 1'b1, "receiver")
      `CHK(kept - k, 13, "receiver discard")
      `CHK(last_word, fmt(14'((cyc - 9) * 37), 1'b1), "receiver word")
      apb(1, adc_out_pkg::CTRL_OFS, 1);
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0, "ctrl standby")
      apb(1, adc_out_pkg::CTRL_OFS, 0);
      wait_valid();
      `CHK(samples_valid, 1'b1, "valid after ctrl wake")
      apb(0, 12'h00c, 32'hffff_ffff);
      `CHK({err, rd}, {1'b1, 32'h0000_0000}, "unmapped")
      apb(1, adc_out_pkg::CTRL_OFS, 2);
      repeat (20) @(posedge ref_clk);
      apb(1, adc_out_pkg::CTRL_OFS, 0);
      apb(0, adc_out_pkg::STATUS_OFS, 0);
      `CHK({rd[9], capture_ready}, 2'b10, "fifo full")
      i = 0;
      repeat (16)
      begin
         apb(0, adc_out_pkg::FIFO_OFS, 0);
         `CHK(rd[31], 1'b1, "fifo word")
         if (i > 0)
            `CHK(rd[13:0], 14'(prev_word + 14'h0025), "fifo order")
         prev_word = rd[13:0];
         i++;
      end
      apb(0, adc_out_pkg::FIFO_OFS, 0);
      `CHK(rd[31], 1'b0, "fifo drained")
      apb(0, adc_out_pkg::STATUS_OFS, 0);
      `CHK(rd[8], 1'b1, "fifo empty")
      print_verdict();
   end
endmodule // tb
